// [hdl/sdgo_defs.svh]
// Register offsets, reset values, keys and timing figures for the serial core.
// Included by the core and by the testbench; holds definitions only.
`ifndef SDGO_DEFS_SVH
`define SDGO_DEFS_SVH

`define SDGO_ADR_NOP 5'h00
`define SDGO_ADR_DAC_INPUT 5'h01
`define SDGO_ADR_DAC_OUTPUT 5'h02
`define SDGO_ADR_SW_LOAD 5'h03
`define SDGO_ADR_GAIN 5'h04
`define SDGO_ADR_OFFSET 5'h05
`define SDGO_ADR_GP_CONFIG 5'h06
`define SDGO_ADR_RB_SELECT 5'h07
`define SDGO_ADR_KEY 5'h08
`define SDGO_ADR_DIAG 5'h09
`define SDGO_ADR_STATUS 5'h0A
`define SDGO_ADR_FAULT_CFG 5'h0B
`define SDGO_ADR_WDT_CFG 5'h0C

`define SDGO_GP_CRC_EN 0
`define SDGO_GP_MODE_LO 1
`define SDGO_GP_WDT_EN 3
`define SDGO_GP_WDT_ANY 4
`define SDGO_DIAG_CRC 0
`define SDGO_DIAG_SLIP 1
`define SDGO_DIAG_SCLK 2
`define SDGO_DIAG_WDT 3
`define SDGO_FC_CRC 0
`define SDGO_FC_WDT 1

`define SDGO_RST_GAIN 16'hFFFF
`define SDGO_RST_OFFSET 16'h8000
`define SDGO_RST_GP 16'h0001
`define SDGO_RST_FAULT_CFG 16'h0003
`define SDGO_RST_WDT_MS 16'h03E8
`define SDGO_WDT_KEY 16'h5A3C
`define SDGO_CRC_POLY 8'h07
`define SDGO_OFFSET_ZERO 18'h08000
`define SDGO_SYNC_BITS 2'h2
`define SDGO_LEN_CRC 6'h20
`define SDGO_LEN_PLAIN 6'h18

`define SDGO_CLK_NS 25
`define SDGO_WDT_TICK_NS 1000000

`endif

// [hdl/sdgo_pkg.sv]
// Types shared by the serial core.
// Assumes sdgo_defs.svh is on the include path.
package sdgo_pkg;
	typedef enum logic [1:0] {RB_TWO_STAGE, RB_AUTO, RB_SHARED, RB_ECHO} sdgo_rb_mode_type;
endpackage

// [hdl/sdgo_spi_core.sv]
// Serial host interface with frame checks, readback modes, watchdog and gain/offset stage.
// Assumes sys_clk is much faster than sclk and that sclk idles high between frames.
`timescale 1ns/1ps
`include "sdgo_defs.svh"

module sdgo_spi_core
	import sdgo_pkg::*;
#(
	parameter int TICK_CYCLES = `SDGO_WDT_TICK_NS / `SDGO_CLK_NS
)
(
	input wire logic sys_clk, // System clock, 40 MHz.
	input wire logic rst_n, // Asynchronous reset.
	input wire logic sclk, // Serial clock from host.
	input wire logic sync_n, // Frame select from host.
	input wire logic sdi, // Serial data in.
	input wire logic addr_sel0, // Device address pin 0.
	input wire logic addr_sel1, // Device address pin 1.
	input wire logic load_converter_n, // Hardware load pin.
	output logic sdo, // Serial data out.
	output logic fault_n, // Fault pin, low on fault.
	output logic [15:0] dac_code // Calibrated code at the converter.
);

	logic [5:0] pin_meta;
	logic [5:0] pin_s;
	logic [3:1] pin_d;
	logic [31:0] rx_sr;
	logic [5:0] rx_cnt;
	logic [31:0] tx_sr;
	logic [15:0] user_gain_trim;
	logic [15:0] user_offset_trim;
	logic [15:0] gp_cfg;
	logic [15:0] fault_cfg;
	logic [15:0] wdt_cfg;
	logic [4:0] rb_sel;
	logic [3:0] diag;
	logic [23:0] last_cmd;
	logic echo_phase;
	logic [15:0] dac_input;
	logic [15:0] dac_out_raw;
	logic [15:0] pend_code;
	logic pend_valid;
	logic [31:0] tick_cnt;
	logic [15:0] wdt_cnt;
	logic wdt_armed;

	// Every pin is foreign to sys_clk, so all pass two flops before use.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_meta <= 6'h3F;
			pin_s <= 6'h3F;
			pin_d <= 3'h7;
		end
		else
		begin
			pin_meta <= {addr_sel1, addr_sel0, load_converter_n, sync_n, sclk, sdi};
			pin_s <= pin_meta;
			pin_d <= pin_s[3:1];
		end
	end

	wire sclk_fall = pin_d[1] & ~pin_s[1];
	wire sclk_rise = ~pin_d[1] & pin_s[1];
	wire sync_fall = pin_d[2] & ~pin_s[2];
	wire sync_rise = ~pin_d[2] & pin_s[2];
	wire in_frame = ~pin_s[2];
	wire load_fall = pin_d[3] & ~pin_s[3];
	wire load_low = ~pin_s[3];

	function automatic logic [7:0] crc8(input logic [23:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 23; i >= 0; i--)
		begin
			if (c[7] ^ d[i])
				c = {c[6:0], 1'b0} ^ `SDGO_CRC_POLY;
			else
				c = {c[6:0], 1'b0};
		end
		return c;
	endfunction

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_sr <= 32'h0;
			rx_cnt <= 6'h0;
		end
		else if (sync_fall)
			rx_cnt <= 6'h0;
		else if (sclk_fall && in_frame)
		begin
			rx_sr <= {rx_sr[30:0], pin_s[0]};
			if (rx_cnt != 6'h3F)
				rx_cnt <= rx_cnt + 6'h1;
		end
	end

	wire crc_en = gp_cfg[`SDGO_GP_CRC_EN];
	wire cnt32 = (rx_cnt == `SDGO_LEN_CRC);
	wire cnt24 = (rx_cnt == `SDGO_LEN_PLAIN);
	wire cnt_ok = crc_en ? cnt32 : (cnt32 | cnt24);
	wire [23:0] word = cnt32 ? rx_sr[31:8] : rx_sr[23:0];
	wire slip_ok = word[23] != word[22];
	wire addr_ok = word[22:21] == pin_s[5:4];
	wire crc_ok = !crc_en || (crc8(word) == rx_sr[7:0]);
	wire ev_cnt = sync_rise & ~cnt_ok;
	wire ev_slip = sync_rise & cnt_ok & ~slip_ok;
	wire ev_crc = sync_rise & cnt_ok & slip_ok & addr_ok & ~crc_ok;
	wire wr_ok = sync_rise & cnt_ok & slip_ok & addr_ok & crc_ok;
	wire [4:0] wr_addr = word[20:16];
	wire [15:0] wr_data = word[15:0];
	wire wdt_fault = diag[`SDGO_DIAG_WDT];
	wire fault_act = (diag[`SDGO_DIAG_CRC] & fault_cfg[`SDGO_FC_CRC])
		| (wdt_fault & fault_cfg[`SDGO_FC_WDT]);
	wire [15:0] status = {13'h0, fault_act, |diag, wdt_fault};
	wire dac_we = wr_ok && wr_addr == `SDGO_ADR_DAC_INPUT && !wdt_fault;
	wire load_ev = ((wr_ok && wr_addr == `SDGO_ADR_SW_LOAD) || load_fall) && !wdt_fault;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			user_gain_trim <= `SDGO_RST_GAIN;
			user_offset_trim <= `SDGO_RST_OFFSET;
			gp_cfg <= `SDGO_RST_GP;
			fault_cfg <= `SDGO_RST_FAULT_CFG;
			wdt_cfg <= `SDGO_RST_WDT_MS;
			rb_sel <= 5'h00;
			last_cmd <= 24'h0;
		end
		else if (wr_ok)
		begin
			last_cmd <= word;
			case (wr_addr)
				`SDGO_ADR_GAIN: user_gain_trim <= wr_data;
				`SDGO_ADR_OFFSET: user_offset_trim <= wr_data;
				`SDGO_ADR_GP_CONFIG: gp_cfg <= wr_data;
				`SDGO_ADR_FAULT_CFG: fault_cfg <= wr_data;
				`SDGO_ADR_WDT_CFG: wdt_cfg <= wr_data;
				`SDGO_ADR_RB_SELECT: rb_sel <= wr_data[4:0];
				default: ;
			endcase
		end
	end

	// New events win over a clear written in the same cycle.
	wire [3:0] diag_clr = (wr_ok && wr_addr == `SDGO_ADR_DIAG) ? wr_data[3:0] : 4'h0;
	logic ev_wdt;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			diag <= 4'h0;
		else
			diag <= (diag & ~diag_clr) | {ev_wdt, ev_cnt, ev_slip, ev_crc};
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			fault_n <= 1'b1;
		else
			fault_n <= ~fault_act;
	end

	wire qualify = wr_ok && (gp_cfg[`SDGO_GP_WDT_ANY]
		|| (wr_addr == `SDGO_ADR_KEY && wr_data == `SDGO_WDT_KEY));
	wire tick = (tick_cnt == 32'(TICK_CYCLES - 1));
	assign ev_wdt = gp_cfg[`SDGO_GP_WDT_EN] && wdt_armed && tick
		&& ({1'b0, wdt_cnt} + 17'h1 >= {1'b0, wdt_cfg});

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			tick_cnt <= 32'h0;
		else if (tick || qualify)
			tick_cnt <= 32'h0;
		else
			tick_cnt <= tick_cnt + 32'h1;
	end

	// A timed-out watchdog stays parked until the flag is cleared and a restart arrives.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wdt_cnt <= 16'h0;
			wdt_armed <= 1'b1;
		end
		else if (qualify && !wdt_fault)
		begin
			wdt_cnt <= 16'h0;
			wdt_armed <= 1'b1;
		end
		else if (ev_wdt)
			wdt_armed <= 1'b0;
		else if (tick && wdt_armed && gp_cfg[`SDGO_GP_WDT_EN])
			wdt_cnt <= wdt_cnt + 16'h1;
	end

	// Calibration uses the gain and offset current at the input write only.
	wire [32:0] prod = wr_data * ({1'b0, user_gain_trim} + 17'h1);
	wire [17:0] sum = {1'b0, prod[32:16]} + {2'b00, user_offset_trim};
	logic [15:0] cal;
	always_comb
	begin
		if (sum < `SDGO_OFFSET_ZERO)
			cal = 16'h0000;
		else if (sum - `SDGO_OFFSET_ZERO > 18'h0FFFF)
			cal = 16'hFFFF;
		else
			cal = 16'(sum - `SDGO_OFFSET_ZERO);
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dac_input <= 16'h0;
			dac_out_raw <= 16'h0;
			pend_code <= 16'h0;
			pend_valid <= 1'b0;
			dac_code <= 16'h0;
		end
		else if (dac_we)
		begin
			dac_input <= wr_data;
			pend_code <= cal;
			pend_valid <= !load_low;
			if (load_low)
			begin
				dac_code <= cal;
				dac_out_raw <= wr_data;
			end
		end
		else if (load_ev && pend_valid)
		begin
			dac_code <= pend_code;
			dac_out_raw <= dac_input;
			pend_valid <= 1'b0;
		end
	end

	sdgo_rb_mode_type rb_mode;
	assign rb_mode = sdgo_rb_mode_type'(gp_cfg[`SDGO_GP_MODE_LO +: 2]);
	logic [4:0] rb_addr;
	logic [15:0] rb_data;
	always_comb
	begin
		rb_addr = (rb_mode == RB_TWO_STAGE) ? rb_sel : `SDGO_ADR_STATUS;
		case (rb_addr)
			`SDGO_ADR_DAC_INPUT: rb_data = dac_input;
			`SDGO_ADR_DAC_OUTPUT: rb_data = dac_out_raw;
			`SDGO_ADR_GAIN: rb_data = user_gain_trim;
			`SDGO_ADR_OFFSET: rb_data = user_offset_trim;
			`SDGO_ADR_GP_CONFIG: rb_data = gp_cfg;
			`SDGO_ADR_RB_SELECT: rb_data = {11'h0, rb_sel};
			`SDGO_ADR_DIAG: rb_data = {12'h0, diag};
			`SDGO_ADR_STATUS: rb_data = status;
			`SDGO_ADR_FAULT_CFG: rb_data = fault_cfg;
			`SDGO_ADR_WDT_CFG: rb_data = wdt_cfg;
			default: rb_data = 16'h0000;
		endcase
		if (rb_mode == RB_ECHO && echo_phase)
		begin
			rb_addr = last_cmd[20:16];
			rb_data = last_cmd[15:0];
		end
	end

	wire [23:0] tx_head = {`SDGO_SYNC_BITS, fault_act, rb_addr, rb_data};

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			echo_phase <= 1'b0;
		else if (sync_fall)
			echo_phase <= (rb_mode == RB_ECHO) ? ~echo_phase : 1'b0;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_sr <= 32'h0;
			sdo <= 1'b0;
		end
		else if (sync_fall)
		begin
			tx_sr <= {tx_head, crc8(tx_head)};
			sdo <= tx_head[23];
		end
		else if (sclk_rise && in_frame)
		begin
			tx_sr <= {tx_sr[30:0], 1'b0};
			sdo <= tx_sr[30];
		end
		else if (sync_rise)
			sdo <= 1'b0;
	end

	sequence s_bad_crc;
		sync_rise && cnt_ok && slip_ok && addr_ok && !crc_ok;
	endsequence

	sequence s_flag_then_fault;
		diag[`SDGO_DIAG_CRC] && fault_cfg[`SDGO_FC_CRC] ##1 !fault_n;
	endsequence

	a_crc_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_bad_crc |=> diag[`SDGO_DIAG_CRC] ##1 !fault_n || !fault_cfg[`SDGO_FC_CRC])
		else $error("CRC error not flagged");
	a_crc_fault_pin: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(diag[`SDGO_DIAG_CRC] && fault_cfg[`SDGO_FC_CRC]) |-> s_flag_then_fault)
		else $error("Fault pin did not follow CRC flag");
	a_crc_flag_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(diag_clr[0] && !ev_crc) |=> !diag[`SDGO_DIAG_CRC])
		else $error("CRC flag did not clear");
	a_slip_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(sync_rise && cnt_ok && word[23] == word[22]) |=> diag[`SDGO_DIAG_SLIP])
		else $error("Slip error not flagged");
	a_count_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(sync_rise && rx_cnt != `SDGO_LEN_CRC && crc_en) |=> diag[`SDGO_DIAG_SCLK])
		else $error("Clock count error not flagged");
	a_gain_no_update: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(wr_ok && wr_addr == `SDGO_ADR_GAIN) |=> $stable(dac_code))
		else $error("Gain write moved the output");
	a_wdt_blocks_input: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(wdt_fault && !load_ev) |=> $stable(dac_code) && $stable(dac_input))
		else $error("Converter changed during watchdog fault");
	a_wdt_timeout_flags: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ev_wdt |=> wdt_fault && status[0] && !wdt_armed)
		else $error("Watchdog timeout not flagged");
	a_rb_sync_bits: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sync_fall |=> sdo && tx_sr[31:30] == `SDGO_SYNC_BITS)
		else $error("Readback frame lacks sync bits");
	a_gain_reset_val: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(rst_n) |-> user_gain_trim == `SDGO_RST_GAIN && user_offset_trim == `SDGO_RST_OFFSET)
		else $error("Gain or offset reset value wrong");

endmodule

// [sim/sdgo_host_model.sv]
// Host side of the serial link: shifts frames out on sdi and gathers sdo.
// Assumes sys_clk paces the link and the core samples sdi on falling sclk.
`timescale 1ns/1ps
module sdgo_host_model
(
	input wire logic sys_clk, // Pacing clock, 25 ns period.
	output logic sclk, // Serial clock, idles high, 200 ns period.
	output logic sync_n, // Frame select, active low.
	output logic sdi, // Serial data to the core.
	input wire logic sdo // Serial data from the core.
);
	initial
	begin
		sclk = 1'b1;
		sync_n = 1'b1;
		sdi = 1'b0;
	end
	task automatic half();
		repeat (4) @(negedge sys_clk);
	endtask
	// Sends n bits of tx and samples sdo just before each rise, while it still stands.
	task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
		rx = 32'h0;
		sync_n = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			sdi = tx[31 - i];
			half();
			sclk = 1'b0;
			half();
			rx = {rx[30:0], sdo};
			sclk = 1'b1;
		end
		half();
		sync_n = 1'b1;
		// A released line must not keep showing the last bit.
		sdi = ~sdi;
		repeat (12) @(negedge sys_clk);
	endtask
endmodule

// [sim/sdgo_spi_core_tb_top.sv]
// Self-checking bench for the serial core, with a host model on the link.
// Assumes the core's register map and timing figures from sdgo_defs.svh.
`timescale 1ns/1ps
`include "sdgo_defs.svh"
module sdgo_spi_core_tb_top;
	logic sys_clk, rst_n, addr_sel0, addr_sel1, load_converter_n;
	wire sclk, sync_n, sdi, sdo, fault_n;
	wire [15:0] dac_code;
	int failures, tests_run, seed;
	logic [31:0] rx, tx;
	logic [23:0] h;
	logic [15:0] gain_m, offs_m, din_m, code_m;
	sdgo_spi_core #(.TICK_CYCLES(10)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .sclk(sclk),
		.sync_n(sync_n), .sdi(sdi), .addr_sel0(addr_sel0), .addr_sel1(addr_sel1),
		.load_converter_n(load_converter_n), .sdo(sdo), .fault_n(fault_n), .dac_code(dac_code));
	sdgo_host_model i_host (.sys_clk(sys_clk), .sclk(sclk), .sync_n(sync_n), .sdi(sdi), .sdo(sdo));
	function automatic logic [7:0] crc8(input logic [23:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 23; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `SDGO_CRC_POLY : 8'h00);
		return c;
	endfunction
	function automatic logic [31:0] mk(input logic [4:0] a, input logic [15:0] d);
		logic [23:0] f;
		f = {~addr_sel1, addr_sel1, addr_sel0, a, d};
		return {f, crc8(f)};
	endfunction
	function automatic logic [15:0] cal(input logic [15:0] d, input logic [15:0] m,
		input logic [15:0] c);
		longint v;
		v = (longint'(d) * (longint'(m) + 1)) / 65536 + longint'(c) - 32768;
		if (v < 0)
			v = 0;
		if (v > 65535)
			v = 65535;
		return v[15:0];
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		tests_run++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		i_host.frame(mk(a, d), 32, rx);
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] exp);
		wr(`SDGO_ADR_RB_SELECT, {11'h000, a});
		wr(`SDGO_ADR_NOP, 16'h0000);
		chk({rx[31:30], rx[28:8]}, {2'b10, a, exp}, "readback frame");
		chk(rx[7:0], crc8(rx[31:8]), "readback check sequence");
	endtask
	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// The run needs about 30000 cycles; the limit leaves ample margin.
	initial
	begin
		#2000000;
		failures++;
		$display("CHECK FAILED at %0t: watchdog limit reached", $time);
		print_verdict();
	end
	initial
	begin
		rst_n = 1'b0;
		addr_sel0 = 1'b0;
		addr_sel1 = 1'b1;
		load_converter_n = 1'b0;
		seed = 80;
		failures = 0;
		tests_run = 0;
		code_m = 16'h0000;
		repeat (6) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge sys_clk);
		chk({fault_n, dac_code}, {1'b1, 16'h0000}, "reset outputs");
		rd(`SDGO_ADR_GAIN, 16'hFFFF);
		rd(`SDGO_ADR_OFFSET, 16'h8000);
		rd(`SDGO_ADR_GP_CONFIG, 16'h0001);
		rd(`SDGO_ADR_FAULT_CFG, 16'h0003);
		rd(`SDGO_ADR_WDT_CFG, 16'h03E8);
		$display("test reset values done");
		for (int i = 0; i < 4; i++)
		begin
			gain_m = 16'($random(seed));
			offs_m = 16'($random(seed));
			wr(`SDGO_ADR_GAIN, gain_m);
			wr(`SDGO_ADR_OFFSET, offs_m);
			chk(dac_code, code_m, "trim write moved output");
			din_m = 16'($random(seed));
			wr(`SDGO_ADR_DAC_INPUT, din_m);
			code_m = cal(din_m, gain_m, offs_m);
			chk(dac_code, code_m, "calibrated code");
			rd(`SDGO_ADR_DAC_OUTPUT, din_m);
			rd(`SDGO_ADR_GAIN, gain_m);
		end
		load_converter_n = 1'b1;
		din_m = 16'($random(seed));
		wr(`SDGO_ADR_DAC_INPUT, din_m);
		chk(dac_code, code_m, "load pin high held output");
		load_converter_n = 1'b0;
		repeat (8) @(negedge sys_clk);
		code_m = cal(din_m, gain_m, offs_m);
		chk(dac_code, code_m, "load pin update");
		load_converter_n = 1'b1;
		din_m = 16'($random(seed));
		wr(`SDGO_ADR_DAC_INPUT, din_m);
		wr(`SDGO_ADR_SW_LOAD, 16'h0000);
		code_m = cal(din_m, gain_m, offs_m);
		chk(dac_code, code_m, "software load update");
		load_converter_n = 1'b0;
		$display("test calibration done");
		for (int k = 0; k < 4; k++)
		begin
			h = {~addr_sel1, addr_sel1, addr_sel0, `SDGO_ADR_GAIN, 16'h1111};
			if (k == 1)
				h[23] = ~h[23];
			if (k == 3)
				h[21] = ~h[21];
			tx = {h, crc8(h)};
			if (k == 0)
				tx[0] = ~tx[0];
			i_host.frame(tx, (k == 2) ? 31 : 32, rx);
			if (k == 0)
				chk(fault_n, 1'b0, "fault pin on bad check");
			rd(`SDGO_ADR_DIAG, (k == 3) ? 16'h0000 : 16'h0001 << k);
			if (k == 0)
				chk(rx[29], 1'b1, "readback fault bit");
			wr(`SDGO_ADR_DIAG, 16'h000F);
			chk(fault_n, 1'b1, "fault pin after clear");
			rd(`SDGO_ADR_GAIN, gain_m);
		end
		wr(`SDGO_ADR_GP_CONFIG, 16'h0000);
		tx = mk(`SDGO_ADR_GAIN, 16'h0F0F);
		tx[7:0] = ~tx[7:0];
		i_host.frame(tx, 32, rx);
		rd(`SDGO_ADR_GAIN, 16'h0F0F);
		i_host.frame(mk(`SDGO_ADR_OFFSET, 16'h7777), 24, rx);
		rd(`SDGO_ADR_OFFSET, 16'h7777);
		gain_m = 16'h0F0F;
		offs_m = 16'h7777;
		wr(`SDGO_ADR_GP_CONFIG, 16'h0001);
		$display("test frame checks done");
		for (int m = 1; m < 3; m++)
		begin
			wr(`SDGO_ADR_GP_CONFIG, {13'h0000, m[1:0], 1'b1});
			wr(`SDGO_ADR_NOP, 16'h0000);
			chk(rx[28:8], {`SDGO_ADR_STATUS, 16'h0000}, "autostatus frame");
		end
		wr(`SDGO_ADR_GP_CONFIG, 16'h0007);
		wr(`SDGO_ADR_RB_SELECT, 16'h0004);
		chk(rx[28:24], `SDGO_ADR_STATUS, "echo first frame");
		wr(`SDGO_ADR_NOP, 16'h0000);
		chk(rx[28:8], {`SDGO_ADR_RB_SELECT, 16'h0004}, "echo of command");
		wr(`SDGO_ADR_GP_CONFIG, 16'h0001);
		$display("test readback modes done");
		wr(`SDGO_ADR_WDT_CFG, 16'd60);
		wr(`SDGO_ADR_GP_CONFIG, 16'h0009);
		repeat (4) wr(`SDGO_ADR_KEY, `SDGO_WDT_KEY);
		chk(fault_n, 1'b1, "key frames keep timer alive");
		repeat (700) @(negedge sys_clk);
		chk(fault_n, 1'b0, "timeout fault pin");
		rd(`SDGO_ADR_STATUS, 16'h0007);
		rd(`SDGO_ADR_DIAG, 16'h0008);
		wr(`SDGO_ADR_DAC_INPUT, ~din_m);
		chk(dac_code, code_m, "write blocked after timeout");
		wr(`SDGO_ADR_GP_CONFIG, 16'h0001);
		wr(`SDGO_ADR_DIAG, 16'h0008);
		chk(fault_n, 1'b1, "fault pin after timeout clear");
		din_m = 16'($random(seed));
		wr(`SDGO_ADR_DAC_INPUT, din_m);
		code_m = cal(din_m, gain_m, offs_m);
		chk(dac_code, code_m, "write accepted after clear");
		wr(`SDGO_ADR_GP_CONFIG, 16'h0019);
		// Four frames span more than one timeout, so only restarts keep the pin high.
		repeat (4) wr(`SDGO_ADR_RB_SELECT, 16'h0000);
		chk(fault_n, 1'b1, "any write keeps timer alive");
		repeat (700) @(negedge sys_clk);
		chk(fault_n, 1'b0, "rearmed watchdog timeout");
		wr(`SDGO_ADR_GP_CONFIG, 16'h0001);
		wr(`SDGO_ADR_DIAG, 16'h0008);
		chk(fault_n, 1'b1, "fault pin after second clear");
		$display("test watchdog done");
		print_verdict();
	end
endmodule
